// [hdl/oam_pkg.sv]
// Package of constants, operation codes and carriers for the operand and timing unit
`default_nettype none
package oam_pkg;
	// ------------------------------------------------------------
	// Reset values and fixed constants
	// ------------------------------------------------------------
	localparam logic [7:0] OAM_REGION_RESET = 8'h01; // Extended region byte after reset
	localparam logic [5:0] OAM_BYTE_REG_MAX = 6'h0f; // Highest file byte register
	localparam logic [5:0] OAM_WORD_REG_MAX = 6'h1e; // Highest file word register
	localparam logic [5:0] OAM_DWORD_LOW_MAX = 6'h1c; // Highest dword register of the low run
	localparam logic [5:0] OAM_DWORD_HI_A = 6'h38; // First upper dword register
	localparam logic [5:0] OAM_DWORD_HI_B = 6'h3c; // Second upper dword register
	localparam logic [7:0] OAM_ADDR_STATES = 8'h01; // States of a pure addressing decode

	// ------------------------------------------------------------
	// Byte and state counts, binary mode then source mode
	// ------------------------------------------------------------
	localparam logic [2:0] OAM_UPPER_BYTES_BIN = 3'h5;
	localparam logic [2:0] OAM_UPPER_BYTES_SRC = 3'h4;
	localparam logic [7:0] OAM_UPPER_STATES_BIN = 8'h03;
	localparam logic [7:0] OAM_UPPER_STATES_SRC = 8'h02;
	localparam logic [2:0] OAM_EXT_BYTES_BIN = 3'h3;
	localparam logic [2:0] OAM_EXT_BYTES_SRC = 3'h2;
	localparam logic [7:0] OAM_EXT_STATES_BIN = 8'h02;
	localparam logic [7:0] OAM_EXT_STATES_SRC = 8'h01;
	localparam logic [7:0] OAM_CODE_STATES = 8'h06;
	localparam logic [7:0] OAM_PTR_RD_STATES_BIN = 8'h04;
	localparam logic [7:0] OAM_PTR_RD_STATES_SRC = 8'h05;
	localparam logic [7:0] OAM_PTR_WR_STATES = 8'h04;
	localparam logic [7:0] OAM_DP_RD_STATES = 8'h03;
	localparam logic [7:0] OAM_DP_WR_STATES = 8'h04;
	localparam logic [7:0] OAM_WAIT_ADD_WR = 8'h01; // Extra beyond N for code read and write
	localparam logic [7:0] OAM_WAIT_ADD_RD = 8'h02; // Extra beyond N for 16-bit read
	localparam logic [2:0] OAM_SWAP_BYTES_BIN = 3'h1;
	localparam logic [2:0] OAM_SWAP_BYTES_SRC = 3'h2;
	localparam logic [7:0] OAM_SWAP_STATES_BIN = 8'h04;
	localparam logic [7:0] OAM_SWAP_STATES_SRC = 8'h05;
	localparam logic [2:0] OAM_STACK_BYTES_BIN = 3'h3;
	localparam logic [2:0] OAM_STACK_BYTES_SRC = 3'h2;
	localparam logic [7:0] OAM_STACK_STATES_BIN = 8'h09;
	localparam logic [7:0] OAM_STACK_STATES_SRC = 8'h08;
	localparam logic [2:0] OAM_IMM_BYTES_BIN = 3'h5;
	localparam logic [2:0] OAM_IMM_BYTES_SRC = 3'h4;
	localparam logic [7:0] OAM_IMM_STATES = 8'h05;
	localparam logic [2:0] OAM_ONE_BYTE = 3'h1;

	// ------------------------------------------------------------
	// Operation codes
	// ------------------------------------------------------------
	typedef enum logic [4:0] {
		OAM_OP_REL_JUMP = 5'h00, OAM_OP_BLOCK_JUMP = 5'h01, OAM_OP_REGION_JUMP = 5'h02,
		OAM_OP_FULL_JUMP = 5'h03, OAM_OP_POINTER_BYTE = 5'h04, OAM_OP_BANK_BYTE = 5'h05,
		OAM_OP_FILE_BYTE = 5'h06, OAM_OP_FILE_WORD = 5'h07, OAM_OP_WORD_IND = 5'h08,
		OAM_OP_WORD_DISP = 5'h09, OAM_OP_FILE_DWORD = 5'h0a, OAM_OP_DWORD_IND = 5'h0b,
		OAM_OP_DWORD_DISP = 5'h0c, OAM_OP_MOVE_UPPER = 5'h0d, OAM_OP_SIGN_EXT = 5'h0e,
		OAM_OP_ZERO_EXT = 5'h0f, OAM_OP_CODE_DP = 5'h10, OAM_OP_CODE_PC = 5'h11,
		OAM_OP_EXT_PTR_RD = 5'h12, OAM_OP_EXT_DP_RD = 5'h13, OAM_OP_EXT_PTR_WR = 5'h14,
		OAM_OP_EXT_DP_WR = 5'h15, OAM_OP_SWAP_NIBBLE = 5'h16, OAM_OP_PUSH_DWORD = 5'h17,
		OAM_OP_POP_DWORD = 5'h18, OAM_OP_PUSH_IMM16 = 5'h19
	} oam_op_t;

	// ------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------
	typedef struct packed {
		oam_op_t op; // Operation to decode
		logic [23:0] next_pc; // Address of the next instruction's first byte
		logic [23:0] operand; // Offset, target, immediate or displacement
		logic [5:0] index; // Register index field n, m, j or k
		logic [1:0] bank; // Currently selected register bank
		logic [7:0] byte_val; // Byte register or memory byte contents
		logic [15:0] word_val; // Word register contents
		logic [31:0] dword_val; // Dword register contents
		logic [7:0] accumulator; // Accumulator contents
		logic [15:0] data_pointer; // Data pointer contents
		logic external; // Access goes to external memory
	} oam_req_t;

	typedef struct packed {
		logic [23:0] address; // Branch target or memory address
		logic [5:0] reg_index; // Register file byte index
		logic index_ok; // Register index is a legal one
		logic [31:0] data; // Value written back
		logic [2:0] bytes; // Instruction length in bytes
		logic [7:0] states; // States spent
	} oam_result_t;
endpackage
`default_nettype wire

// [hdl/oam_exec.sv]
// Operand addressing, move, stack and timing unit of the core
`default_nettype none
//
// Contract
// RULE_01: Relative branch adds signed byte to next PC
// RULE_02: 11-bit target stays in same 2K block
// RULE_03: 16-bit target stays in same 64K region
// RULE_04: 24-bit target loads whole program counter
// RULE_05: Pointer byte register reaches 00h to FFh
// RULE_06: Bank byte register picks R0-R7 of bank
// RULE_07: File byte register picks index 0-15
// RULE_08: Word index even 0-30; indirect jump in 64K
// RULE_09: Word displacement adds signed 16-bit value
// RULE_10: Dword index 0..28 by four, 56, 60
// RULE_11: Upper-half move loads bits 31:16, 5/4 bytes
// RULE_12: Extend moves fill upper byte, 2/1 states
// RULE_13: Code byte read takes six states
// RULE_14: Extended moves use region byte, reset 01h
// RULE_15: External code read or write adds N+1
// RULE_16: 16-bit extended read three plus N+2
// RULE_17: 8-bit extended read four or five states
// RULE_18: Nibble swap exchanges low four bits only
// RULE_19: Dword push takes nine or eight states
// RULE_20: Dword pop takes nine or eight states
// RULE_21: Immediate word push 5/4 bytes, 5 states
// RULE_22: Opcode mode strap is fixed at reset
//
module oam_exec
	import oam_pkg::*;
#(
	parameter int WAIT_W = 2 // Width of the wait-state count N
)(
	input wire logic i_mclk, // System clock
	input wire logic i_rst, // Asynchronous reset, active high
	input wire logic i_source_mode, // Mode strap: high selects source mode
	input wire logic [WAIT_W-1:0] i_wait_states, // Configured wait states N
	input wire logic i_req_valid, // Request strobe, taken while idle
	input wire oam_req_t i_req, // Request fields
	input wire logic i_region_wr, // Load the extended region byte
	input wire logic [7:0] i_region_data, // New extended region byte
	output logic o_busy, // Instruction in progress
	output logic o_done, // One-cycle completion pulse
	output oam_result_t o_result, // Result, valid with o_done and held after
	output logic o_source_mode, // Opcode mode in force
	output logic [7:0] o_region // Extended region byte
);
	// ------------------------------------------------------------
	// Elaboration check
	// ------------------------------------------------------------
	// Counts are held in eight bits, so N must stay small enough
	if (WAIT_W < 1 || WAIT_W > 4) begin : g_bad_wait
		$error("WAIT_W must lie between 1 and 4");
	end

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		OAM_ST_IDLE = 3'b001, // Waiting for a request
		OAM_ST_EXEC = 3'b010, // Counting states
		OAM_ST_DONE = 3'b100 // Completion cycle
	} oam_state_t;

	oam_state_t state; // Sequencer state
	oam_state_t next_state;
	logic [7:0] cnt; // States still to run
	logic [7:0] next_cnt;
	logic mode_taken; // Strap has been caught
	logic next_mode_taken;
	logic source_mode; // Caught strap
	logic next_source_mode;
	logic [7:0] region; // Extended region byte
	logic [7:0] next_region;
	oam_result_t result; // Registered result
	oam_result_t next_result;
	oam_result_t calc; // Decoded result of the present request
	logic busy;
	logic next_busy;
	logic done;
	logic next_done;
	logic [7:0] wait_n; // N widened to counter width
	logic accept; // Request taken this cycle

	assign wait_n = 8'(i_wait_states);
	assign accept = i_req_valid && (state == OAM_ST_IDLE);

	// ------------------------------------------------------------
	// Mode strap and region byte
	// ------------------------------------------------------------
	// Strap is caught once on the first edge after release; a flop under
	// asynchronous reset may only take a constant, hence the extra flag
	always_comb
	begin
		next_mode_taken = 1'b1;
		next_source_mode = source_mode;
		if (!mode_taken)
		begin
			next_source_mode = i_source_mode; // RULE_22
		end
		next_region = region;
		if (i_region_wr)
		begin
			next_region = i_region_data;
		end
	end

	always_ff @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
		begin
			mode_taken <= 1'b0;
			source_mode <= 1'b0;
			region <= OAM_REGION_RESET; // RULE_14
		end
		else
		begin
			mode_taken <= next_mode_taken;
			source_mode <= next_source_mode;
			region <= next_region;
		end
	end

	// ------------------------------------------------------------
	// Operand decode and timing
	// ------------------------------------------------------------
	// One pass computes address, data, length and state count; the
	// sequencer then spends the state count before answering
	always_comb
	begin
		calc = '0;
		calc.states = OAM_ADDR_STATES;
		calc.index_ok = 1'b1;
		case (i_req.op)
			OAM_OP_REL_JUMP:
			begin
				// Sign extension gives the -128 to +127 reach
				calc.address = i_req.next_pc + {{16{i_req.operand[7]}}, i_req.operand[7:0]}; // RULE_01
			end
			OAM_OP_BLOCK_JUMP:
			begin
				calc.address = {i_req.next_pc[23:11], i_req.operand[10:0]}; // RULE_02
			end
			OAM_OP_REGION_JUMP:
			begin
				calc.address = {i_req.next_pc[23:16], i_req.operand[15:0]}; // RULE_03
			end
			OAM_OP_FULL_JUMP:
			begin
				calc.address = i_req.operand; // RULE_04
			end
			OAM_OP_POINTER_BYTE:
			begin
				// Only registers zero and one may be pointers
				calc.address = {16'h0000, i_req.byte_val}; // RULE_05
				calc.index_ok = (i_req.index[5:1] == 5'h00);
			end
			OAM_OP_BANK_BYTE:
			begin
				calc.reg_index = {1'b0, i_req.bank, i_req.index[2:0]}; // RULE_06
				calc.index_ok = (i_req.index[5:3] == 3'h0);
			end
			OAM_OP_FILE_BYTE:
			begin
				calc.reg_index = i_req.index; // RULE_07
				calc.index_ok = (i_req.index <= OAM_BYTE_REG_MAX);
			end
			OAM_OP_FILE_WORD, OAM_OP_WORD_IND:
			begin
				calc.reg_index = i_req.index;
				calc.index_ok = !i_req.index[0] && (i_req.index <= OAM_WORD_REG_MAX); // RULE_08
				calc.address = {8'h00, i_req.word_val}; // RULE_08
			end
			OAM_OP_WORD_DISP:
			begin
				// Address wraps inside the first 64K
				calc.reg_index = i_req.index;
				calc.index_ok = !i_req.index[0] && (i_req.index <= OAM_WORD_REG_MAX);
				calc.address = {8'h00, i_req.word_val + i_req.operand[15:0]}; // RULE_09
			end
			OAM_OP_FILE_DWORD, OAM_OP_DWORD_IND, OAM_OP_DWORD_DISP:
			begin
				calc.reg_index = i_req.index;
				calc.index_ok = (i_req.index[1:0] == 2'h0) && // RULE_10
					((i_req.index <= OAM_DWORD_LOW_MAX) || (i_req.index == OAM_DWORD_HI_A) ||
					(i_req.index == OAM_DWORD_HI_B));
				calc.address = i_req.dword_val[23:0]; // RULE_10
				if (i_req.op == OAM_OP_DWORD_DISP)
				begin
					calc.address = i_req.dword_val[23:0] +
						{{8{i_req.operand[15]}}, i_req.operand[15:0]};
				end
			end
			OAM_OP_MOVE_UPPER:
			begin
				calc.reg_index = i_req.index;
				calc.data = {i_req.operand[15:0], i_req.dword_val[15:0]}; // RULE_11
				calc.bytes = source_mode ? OAM_UPPER_BYTES_SRC : OAM_UPPER_BYTES_BIN; // RULE_11
				calc.states = source_mode ? OAM_UPPER_STATES_SRC : OAM_UPPER_STATES_BIN;
			end
			OAM_OP_SIGN_EXT, OAM_OP_ZERO_EXT:
			begin
				calc.reg_index = i_req.index;
				if (i_req.op == OAM_OP_SIGN_EXT)
				begin
					calc.data = {16'h0000, {8{i_req.byte_val[7]}}, i_req.byte_val}; // RULE_12
				end
				else
				begin
					calc.data = {24'h000000, i_req.byte_val}; // RULE_12
				end
				calc.bytes = source_mode ? OAM_EXT_BYTES_SRC : OAM_EXT_BYTES_BIN;
				calc.states = source_mode ? OAM_EXT_STATES_SRC : OAM_EXT_STATES_BIN; // RULE_12
			end
			OAM_OP_CODE_DP, OAM_OP_CODE_PC:
			begin
				// Index sum wraps within its base's 64K region
				if (i_req.op == OAM_OP_CODE_DP)
				begin
					calc.address = {region, i_req.data_pointer + {8'h00, i_req.accumulator}};
				end
				else
				begin
					calc.address = {i_req.next_pc[23:16],
						i_req.next_pc[15:0] + {8'h00, i_req.accumulator}};
				end
				calc.bytes = OAM_ONE_BYTE;
				calc.states = OAM_CODE_STATES; // RULE_13
				if (i_req.external)
				begin
					calc.states = OAM_CODE_STATES + wait_n + OAM_WAIT_ADD_WR; // RULE_15
				end
			end
			OAM_OP_EXT_PTR_RD, OAM_OP_EXT_PTR_WR:
			begin
				calc.address = {region, 8'h00, i_req.byte_val}; // RULE_14
				calc.data = {24'h000000, i_req.accumulator};
				calc.bytes = OAM_ONE_BYTE;
				if (i_req.op == OAM_OP_EXT_PTR_RD)
				begin
					calc.states = source_mode ? OAM_PTR_RD_STATES_SRC : OAM_PTR_RD_STATES_BIN; // RULE_17
				end
				else
				begin
					calc.states = OAM_PTR_WR_STATES;
				end
			end
			OAM_OP_EXT_DP_RD:
			begin
				calc.address = {region, i_req.data_pointer}; // RULE_14
				calc.bytes = OAM_ONE_BYTE;
				calc.states = OAM_DP_RD_STATES; // RULE_16
				if (i_req.external)
				begin
					calc.states = OAM_DP_RD_STATES + wait_n + OAM_WAIT_ADD_RD; // RULE_16
				end
			end
			OAM_OP_EXT_DP_WR:
			begin
				calc.address = {region, i_req.data_pointer}; // RULE_14
				calc.data = {24'h000000, i_req.accumulator};
				calc.bytes = OAM_ONE_BYTE;
				calc.states = OAM_DP_WR_STATES;
				if (i_req.external)
				begin
					calc.states = OAM_DP_WR_STATES + wait_n + OAM_WAIT_ADD_WR; // RULE_15
				end
			end
			OAM_OP_SWAP_NIBBLE:
			begin
				// Upper byte is the new accumulator, lower the new memory byte
				calc.address = {16'h0000, i_req.operand[7:0]}; // RULE_18
				calc.data = {16'h0000, i_req.accumulator[7:4], i_req.byte_val[3:0],
					i_req.byte_val[7:4], i_req.accumulator[3:0]}; // RULE_18
				calc.bytes = source_mode ? OAM_SWAP_BYTES_SRC : OAM_SWAP_BYTES_BIN;
				calc.states = source_mode ? OAM_SWAP_STATES_SRC : OAM_SWAP_STATES_BIN; // RULE_18
			end
			OAM_OP_PUSH_DWORD, OAM_OP_POP_DWORD:
			begin
				calc.reg_index = i_req.index;
				calc.data = i_req.dword_val;
				calc.address = i_req.operand;
				calc.bytes = source_mode ? OAM_STACK_BYTES_SRC : OAM_STACK_BYTES_BIN;
				calc.states = source_mode ? OAM_STACK_STATES_SRC : OAM_STACK_STATES_BIN; // RULE_19 RULE_20
			end
			OAM_OP_PUSH_IMM16:
			begin
				calc.address = i_req.operand;
				calc.data = {16'h0000, i_req.operand[15:0]};
				calc.bytes = source_mode ? OAM_IMM_BYTES_SRC : OAM_IMM_BYTES_BIN; // RULE_21
				calc.states = OAM_IMM_STATES; // RULE_21
			end
			default:
			begin
				// Unknown code decodes to an illegal operand
				calc.index_ok = 1'b0;
			end
		endcase
	end

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	// One cycle is spent per state so that the answer time is the timing
	always_comb
	begin
		next_state = state;
		next_cnt = cnt;
		next_result = result;
		next_busy = busy;
		next_done = 1'b0;
		case (state)
			OAM_ST_IDLE:
			begin
				if (accept)
				begin
					next_result = calc;
					next_cnt = calc.states;
					next_busy = 1'b1;
					next_state = OAM_ST_EXEC;
				end
			end
			OAM_ST_EXEC:
			begin
				// Counting down to one marks the last state
				if (cnt <= 8'h01)
				begin
					next_done = 1'b1;
					next_state = OAM_ST_DONE;
				end
				else
				begin
					next_cnt = cnt - 8'h01;
				end
			end
			OAM_ST_DONE:
			begin
				next_busy = 1'b0;
				next_cnt = 8'h00;
				next_state = OAM_ST_IDLE;
			end
			default:
			begin
				next_state = OAM_ST_IDLE;
				next_busy = 1'b0;
			end
		endcase
	end

	always_ff @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
		begin
			state <= OAM_ST_IDLE;
			cnt <= 8'h00;
			result <= '0;
			busy <= 1'b0;
			done <= 1'b0;
		end
		else
		begin
			state <= next_state;
			cnt <= next_cnt;
			result <= next_result;
			busy <= next_busy;
			done <= next_done;
		end
	end

	// ------------------------------------------------------------
	// Outputs, all from flops
	// ------------------------------------------------------------
	assign o_busy = busy;
	assign o_done = done;
	assign o_result = result;
	assign o_source_mode = source_mode;
	assign o_region = region;
endmodule // oam_exec
`default_nettype wire

// [dv/oam_mem_model.sv]
// Far-side memory model answering byte reads, fast or slow
`default_nettype none
module oam_mem_model (
	input wire logic i_mclk, // System clock
	input wire logic i_rd, // Read request, held until acknowledged
	input wire logic i_slow, // Answer two cycles late
	input wire logic [7:0] i_addr, // Byte address
	output logic o_ack, // One-cycle acknowledge
	output logic [7:0] o_data // Byte read, valid with o_ack
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] dly; // Cycles waited on this read
	// ------------------------------------------------------------
	// Read answer
	// ------------------------------------------------------------
	// Data churns between reads so a stale byte never passes as an answer
	always @(posedge i_mclk)
	begin
		if (!i_rd || o_ack)
		begin
			o_ack <= 1'b0;
			o_data <= ~o_data;
			dly <= 2'h0;
		end
		else if (dly == {i_slow, 1'b0})
		begin
			o_ack <= 1'b1;
			o_data <= i_addr ^ 8'h5a; // Pattern keyed by address
		end
		else
			dly <= dly + 2'h1;
	end
endmodule // oam_mem_model
`default_nettype wire

// [dv/oam_exec_asserts.sv]
// Assertion checker bound to the ports of the operand and timing unit
`default_nettype none
module oam_exec_asserts
	import oam_pkg::*;
#(
	parameter int WAIT_W = 2 // Width of the wait-state count
)(
	input wire logic i_mclk, // System clock
	input wire logic i_rst, // Asynchronous reset
	input wire logic i_source_mode, // Mode strap
	input wire logic [WAIT_W-1:0] i_wait_states, // Wait states N
	input wire logic i_req_valid, // Request strobe
	input wire oam_req_t i_req, // Request fields
	input wire logic i_region_wr, // Region byte load
	input wire logic [7:0] i_region_data, // New region byte
	input wire logic o_busy, // Instruction in progress
	input wire logic o_done, // Completion pulse
	input wire oam_result_t o_result, // Result
	input wire logic o_source_mode, // Mode in force
	input wire logic [7:0] o_region // Region byte
);
	// ------------------------------------------------------------
	// Helper logic
	// ------------------------------------------------------------
	logic take; // Request accepted at this edge
	logic [7:0] age; // Edges since last accept
	logic [7:0] next_age; // Next value of age
	assign take = i_req_valid && !o_busy && !o_done;
	// Saturate so a long idle spell never wraps
	always_comb
	begin
		next_age = age;
		if (take)
			next_age = 8'h00;
		else if (age != 8'hff)
			next_age = age + 8'h01;
	end
	always_ff @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
			age <= 8'h00;
		else
			age <= next_age;
	end
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (i_rst);
	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	a_done_timing: assert property (o_done |-> age == o_result.states)
		else $error("done pulse not at the stated count");
	a_done_single: assert property (o_done |=> !o_done && !o_busy)
		else $error("done pulse or busy lasts too long");
	a_region_reset: assert property (disable iff (1'b0) i_rst |-> o_region == 8'h01)
		else $error("region byte wrong in reset");
	a_region_load: assert property (i_region_wr |=> o_region == $past(i_region_data))
		else $error("region byte not loaded");
	a_mode_fixed: assert property (!$past(i_rst, 2) |-> $stable(o_source_mode))
		else $error("mode changed after reset");
	a_rel_target: assert property (take && i_req.op == OAM_OP_REL_JUMP |=>
		o_result.address == $past(i_req.next_pc)
		+ {{16{$past(i_req.operand[7])}}, $past(i_req.operand[7:0])})
		else $error("relative target wrong");
	a_block_target: assert property (take && i_req.op == OAM_OP_BLOCK_JUMP |=>
		o_result.address == {$past(i_req.next_pc[23:11]), $past(i_req.operand[10:0])})
		else $error("block target left its block");
	a_upper_data: assert property (take && i_req.op == OAM_OP_MOVE_UPPER |=>
		o_result.data == {$past(i_req.operand[15:0]), $past(i_req.dword_val[15:0])})
		else $error("upper half move data wrong");
	a_code_states: assert property (take && i_req.op inside
		{OAM_OP_CODE_DP, OAM_OP_CODE_PC} |=> o_result.states ==
		($past(i_req.external) ? 8'h07 + 8'($past(i_wait_states)) : 8'h06))
		else $error("code read state count wrong");
	a_swap_nibble: assert property (take && i_req.op == OAM_OP_SWAP_NIBBLE |=>
		o_result.data[15:8] == {$past(i_req.accumulator[7:4]), $past(i_req.byte_val[3:0])})
		else $error("nibble swap wrong");
	c_source_take: cover property (take && o_source_mode);
	c_long_wait: cover property (o_done && o_result.states > 8'h08);
	c_ext_read: cover property (take && i_req.external && i_req.op == OAM_OP_EXT_DP_RD);
endmodule // oam_exec_asserts
bind oam_exec oam_exec_asserts #(.WAIT_W(WAIT_W)) i_oam_exec_asserts (.i_mclk(i_mclk),
	.i_rst(i_rst), .i_source_mode(i_source_mode), .i_wait_states(i_wait_states),
	.i_req_valid(i_req_valid), .i_req(i_req), .i_region_wr(i_region_wr),
	.i_region_data(i_region_data), .o_busy(o_busy), .o_done(o_done), .o_result(o_result),
	.o_source_mode(o_source_mode), .o_region(o_region));
`default_nettype wire

// [dv/oam_exec_tb.sv]
// Self-checking bench for the operand and timing unit
`default_nettype none
module oam_exec_tb
	import oam_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_mclk = 1'b0; // System clock
	logic i_rst = 1'b0; // Reset, raised at time zero
	logic i_source_mode = 1'b0; // Mode strap
	logic [1:0] i_wait_states = 2'h0; // Wait states N
	logic i_req_valid = 1'b0; // Request strobe
	oam_req_t i_req = '0; // Request fields
	logic i_region_wr = 1'b0; // Region byte load
	logic [7:0] i_region_data = 8'h00; // New region byte
	logic o_busy, o_done, o_source_mode;
	oam_result_t o_result;
	logic [7:0] o_region;
	logic mem_rd = 1'b0; // Far-side read request
	logic mem_slow = 1'b0; // Far side answers slowly
	logic [7:0] mem_addr = 8'h00;
	logic mem_ack;
	logic [7:0] mem_data;
	int n_errors = 0;
	int cmp_count = 0;
	logic [31:0] seed = 32'ha8d8; // Random source state
	logic [31:0] t; // Scratch random word
	logic src; // Mode strapped in this phase
	logic [7:0] region; // Region byte last loaded
	always #10 i_mclk = ~i_mclk;
	oam_exec #(.WAIT_W(2)) i_oam_exec (.i_mclk(i_mclk), .i_rst(i_rst),
		.i_source_mode(i_source_mode), .i_wait_states(i_wait_states), .i_req_valid(i_req_valid),
		.i_req(i_req), .i_region_wr(i_region_wr), .i_region_data(i_region_data), .o_busy(o_busy),
		.o_done(o_done), .o_result(o_result), .o_source_mode(o_source_mode), .o_region(o_region));
	oam_mem_model i_oam_mem_model (.i_mclk(i_mclk), .i_rd(mem_rd), .i_slow(mem_slow),
		.i_addr(mem_addr), .o_ack(mem_ack), .o_data(mem_data));
	// ------------------------------------------------------------
	// Helpers and reference model
	// ------------------------------------------------------------
	function automatic logic [31:0] rnd();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed;
	endfunction
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic conclude();
		$display("errors %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	function automatic int exp_states(oam_op_t op, logic s, logic ext, int n);
		case (op)
			OAM_OP_MOVE_UPPER: return s ? 2 : 3;
			OAM_OP_SIGN_EXT, OAM_OP_ZERO_EXT: return s ? 1 : 2;
			OAM_OP_CODE_DP, OAM_OP_CODE_PC: return ext ? 7 + n : 6;
			OAM_OP_EXT_PTR_RD: return s ? 5 : 4;
			OAM_OP_EXT_DP_RD: return ext ? 5 + n : 3;
			OAM_OP_EXT_PTR_WR: return 4;
			OAM_OP_EXT_DP_WR: return ext ? 5 + n : 4;
			OAM_OP_SWAP_NIBBLE: return s ? 5 : 4;
			OAM_OP_PUSH_DWORD, OAM_OP_POP_DWORD: return s ? 8 : 9;
			OAM_OP_PUSH_IMM16: return 5;
			default: return 1;
		endcase
	endfunction
	function automatic int exp_bytes(oam_op_t op, logic s);
		case (op)
			OAM_OP_MOVE_UPPER, OAM_OP_PUSH_IMM16: return s ? 4 : 5;
			OAM_OP_SIGN_EXT, OAM_OP_ZERO_EXT, OAM_OP_PUSH_DWORD, OAM_OP_POP_DWORD: return s ? 2 : 3;
			OAM_OP_SWAP_NIBBLE: return s ? 2 : 1;
			default: return op inside {[OAM_OP_CODE_DP:OAM_OP_EXT_DP_WR]};
		endcase
	endfunction
	// Far-side read, held until the acknowledge is sampled
	task automatic mem_read(input logic [7:0] a, output logic [7:0] d);
		int k;
		@(negedge i_mclk);
		t = rnd();
		mem_addr <= a;
		mem_slow <= t[0];
		mem_rd <= 1'b1;
		k = 0;
		do
		begin
			@(posedge i_mclk);
			k++;
		end
		while (mem_ack !== 1'b1 && k < 20);
		if (mem_ack !== 1'b1)
		begin
			n_errors++;
			conclude();
		end
		d = mem_data;
		@(negedge i_mclk);
		mem_rd <= 1'b0;
	endtask
	// ------------------------------------------------------------
	// One instruction, with a refused request while busy
	// ------------------------------------------------------------
	task automatic run_op(input oam_op_t op);
		oam_req_t r;
		logic [191:0] w;
		logic [7:0] b;
		int k;
		int s;
		w = {rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
		r = w[$bits(oam_req_t)-1:0];
		r.op = op;
		if (op == OAM_OP_BANK_BYTE)
			r.index[5:3] = 3'h0; // Bank form carries only three index bits
		mem_read(r.operand[7:0], b);
		r.byte_val = b;
		i_req <= r;
		i_wait_states <= w[191:190];
		i_req_valid <= 1'b1;
		@(negedge i_mclk);
		i_req <= ~r; // Must be ignored while busy
		@(negedge i_mclk);
		i_req_valid <= 1'b0;
		k = 1;
		while (o_done !== 1'b1 && k < 40)
		begin
			@(negedge i_mclk);
			k++;
		end
		if (k >= 40)
		begin
			n_errors++;
			conclude();
		end
		s = exp_states(op, src, r.external, int'(w[191:190]));
		check("cycles", k, s);
		check("states", o_result.states, s);
		check("bytes", o_result.bytes, exp_bytes(op, src));
		case (op)
			OAM_OP_REL_JUMP: check("rel", o_result.address,
				24'(r.next_pc + {{16{r.operand[7]}}, r.operand[7:0]}));
			OAM_OP_BLOCK_JUMP: check("blk", o_result.address, {r.next_pc[23:11], r.operand[10:0]});
			OAM_OP_REGION_JUMP: check("rgn", o_result.address, {r.next_pc[23:16], r.operand[15:0]});
			OAM_OP_FULL_JUMP: check("full", o_result.address, r.operand);
			OAM_OP_POINTER_BYTE: check("ptr", o_result.index_ok, r.index < 6'h02);
			OAM_OP_BANK_BYTE: check("bank", o_result.reg_index, {1'b0, r.bank, r.index[2:0]});
			OAM_OP_FILE_BYTE: check("fbyte", o_result.index_ok, r.index <= 6'h0f);
			OAM_OP_FILE_WORD: check("fword", o_result.index_ok, !r.index[0] && r.index <= 6'h1e);
			OAM_OP_WORD_DISP: check("disp", o_result.address,
				{8'h00, 16'(r.word_val + r.operand[15:0])});
			OAM_OP_FILE_DWORD: check("fdw", o_result.index_ok,
				r.index[1:0] == 2'h0 && (r.index <= 6'h1c || r.index >= 6'h38));
			OAM_OP_MOVE_UPPER: check("upper", o_result.data, {r.operand[15:0], r.dword_val[15:0]});
			OAM_OP_SIGN_EXT: check("sext", o_result.data[15:0], {{8{b[7]}}, b});
			OAM_OP_ZERO_EXT: check("zext", o_result.data[15:0], {8'h00, b});
			OAM_OP_EXT_PTR_RD: check("xptr", o_result.address, {region, 8'h00, b});
			OAM_OP_SWAP_NIBBLE: check("swap", o_result.data[15:0],
				{r.accumulator[7:4], b[3:0], b[7:4], r.accumulator[3:0]});
			default: ;
		endcase
		@(negedge i_mclk);
		check("idle", {o_busy, o_done}, 2'h0);
	endtask
	// ------------------------------------------------------------
	// Main sequence: one reset phase per mode
	// ------------------------------------------------------------
	initial
	begin
		for (int p = 0; p < 2; p++)
		begin
			src = p[0];
			i_rst <= 1'b1;
			i_source_mode <= src;
			repeat (3) @(negedge i_mclk);
			check("region", o_region, 8'h01);
			i_rst <= 1'b0;
			repeat (2) @(negedge i_mclk);
			i_source_mode <= ~src; // Strap moves after capture, must not take
			check("mode", o_source_mode, src);
			for (int q = 0; q < 3; q++)
			begin
				t = rnd();
				region = t[7:0];
				i_region_wr <= 1'b1;
				i_region_data <= region;
				@(negedge i_mclk);
				i_region_wr <= 1'b0;
				check("region", o_region, region);
				for (int o = 0; o < 26; o++)
					run_op(oam_op_t'(o));
			end
			check("mode", o_source_mode, src);
		end
		conclude();
	end
endmodule // oam_exec_tb
`default_nettype wire
